// ### logic/msbtl_link.sv
`timescale 1ns/100ps
module msbtl_link #(
    parameter int QUIET_CYCLES = msbtl_pkg::QUIET_CYC,
    parameter int CHAR_CYCLES = msbtl_pkg::BYTE_TIME_CYC,
    parameter int TIMEOUT_CYCLES = msbtl_pkg::TMO_CYC,
    parameter int BLK_BYTES = msbtl_pkg::BLOCK_MAX
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [6:0] unit_id_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] blk_count_i,
    input wire logic [8:0] last_len_i,
    input wire logic [7:0] blk_data_i,
    input wire logic blk_data_valid_i,
    output logic blk_data_ready_o,
    input wire logic blk_ok_i,
    output logic [7:0] rx_byte_o,
    output logic rx_byte_valid_o,
    output logic [7:0] hdr_byte_o,
    output logic [4:0] hdr_pos_o,
    output logic hdr_byte_valid_o,
    output logic hdr_ok_o,
    output logic write_dir_o,
    output logic blk_end_o,
    output logic busy_o,
    output logic done_o,
    output logic abort_o
);
    import msbtl_pkg::*;

    function automatic logic is_hex(input logic [7:0] b);
        is_hex = (b >= 8'h30 && b <= 8'h39) || (b >= 8'h41 && b <= 8'h46);
    endfunction

    msbtl_state_t state, next_state;
    logic [1:0] enq_pos;
    logic [31:0] timer;
    logic [4:0] hdr_cnt;
    logic [7:0] lrc;
    logic hdr_bad;
    logic [1:0] retries;
    logic [8:0] byte_cnt;
    logic [7:0] blk_idx;
    logic got_first;
    logic [7:0] reply;
    logic reply_pend;
    // Two-entry skid buffer toward the UART
    logic [7:0] buf_data [2];
    logic [1:0] buf_cnt;
    logic buf_wr_ptr, buf_rd_ptr;

    wire [7:0] own_addr = {1'b0, unit_id_i} + ADDR_OFFSET;
    wire buf_full = (buf_cnt == 2'h2);
    wire buf_push = reply_pend && !buf_full;
    wire src_push = (state == ST_TX_BLK) && blk_data_valid_i && !buf_full && !reply_pend;
    wire buf_pop = tx_valid_o && tx_ready_i;
    wire timer_done = (timer == 32'h0);
    wire last_blk = (blk_idx == blk_count_i);
    wire [8:0] blk_len = last_blk ? last_len_i : 9'(BLK_BYTES);
    wire [4:0] hdr_next = hdr_cnt + 5'h1;
    wire hdr_field_ok = (hdr_cnt == 5'h0) ? (rx_data_i == CH_SOH) :
        (hdr_cnt == 5'(HDR_LEN - 2)) ? (rx_data_i == CH_ETB) :
        (hdr_cnt == 5'(HDR_LEN - 1)) ? (rx_data_i == lrc) :
        is_hex(rx_data_i);
    wire [7:0] lrc_next = (hdr_cnt >= 5'h1 && hdr_cnt < 5'(HDR_FIELD_LAST)) ?
        (lrc ^ rx_data_i) : lrc;

    assign tx_data_o = buf_data[buf_rd_ptr];
    assign tx_valid_o = (buf_cnt != 2'h0);
    assign blk_data_ready_o = (state == ST_TX_BLK) && !buf_full && !reply_pend;
    assign busy_o = (state != ST_HUNT) && (state != ST_QUIET);

    // Byte sends come from the controller; blocks stream through the buffer
    always_comb begin
        next_state = state;
        case (state)
            ST_HUNT: next_state = state;
            ST_QUIET: begin
                if (rx_valid_i) begin
                    next_state = ST_HUNT;
                end else if (timer_done) begin
                    next_state = ST_HDR;
                end
            end
            default: next_state = state;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_HUNT;
            enq_pos <= 2'h0;
            timer <= 32'h0;
            hdr_cnt <= 5'h0;
            lrc <= 8'h0;
            hdr_bad <= 1'b0;
            retries <= 2'h0;
            byte_cnt <= 9'h0;
            blk_idx <= 8'h0;
            got_first <= 1'b0;
            reply <= 8'h0;
            reply_pend <= 1'b0;
            rx_byte_o <= 8'h0;
            rx_byte_valid_o <= 1'b0;
            hdr_byte_o <= 8'h0;
            hdr_pos_o <= 5'h0;
            hdr_byte_valid_o <= 1'b0;
            hdr_ok_o <= 1'b0;
            write_dir_o <= 1'b0;
            blk_end_o <= 1'b0;
            done_o <= 1'b0;
            abort_o <= 1'b0;
        end else begin
            rx_byte_valid_o <= 1'b0;
            hdr_byte_valid_o <= 1'b0;
            hdr_ok_o <= 1'b0;
            blk_end_o <= 1'b0;
            done_o <= 1'b0;
            abort_o <= 1'b0;
            if (buf_push) begin
                reply_pend <= 1'b0;
            end
            if (timer != 32'h0) begin
                timer <= timer - 32'h1;
            end
            case (state)
                ST_HUNT: begin
                    // Unit only answers; it never starts a sequence
                    if (rx_valid_i) begin
                        if (rx_data_i == CH_NORMAL) begin
                            enq_pos <= 2'h1;
                        end else if (enq_pos == 2'h1 && rx_data_i == own_addr) begin
                            enq_pos <= 2'h2;
                        end else if (enq_pos == 2'h2 && rx_data_i == CH_ENQ) begin
                            enq_pos <= 2'h0;
                            state <= ST_QUIET;
                            timer <= 32'(QUIET_CYCLES + QUIET_CHARS * CHAR_CYCLES);
                        end else begin
                            enq_pos <= 2'h0;
                        end
                    end
                end
                ST_QUIET: begin
                    state <= next_state;
                    if (next_state == ST_HDR && !reply_pend) begin
                        reply <= CH_ACK;
                        reply_pend <= 1'b1;
                        timer <= 32'(TIMEOUT_CYCLES);
                        hdr_cnt <= 5'h0;
                        lrc <= 8'h0;
                        hdr_bad <= 1'b0;
                        retries <= 2'h0;
                    end
                end
                ST_HDR: begin
                    if (rx_valid_i) begin
                        hdr_byte_o <= rx_data_i;
                        hdr_pos_o <= hdr_next;
                        hdr_byte_valid_o <= 1'b1;
                        lrc <= lrc_next;
                        hdr_bad <= hdr_bad | !hdr_field_ok;
                        if (hdr_next == 5'(HDR_DIR_POS)) begin
                            write_dir_o <= (rx_data_i != DIR_READ);
                        end
                        if (hdr_next == 5'(HDR_LEN)) begin
                            state <= ST_HDR_ANS;
                        end
                        hdr_cnt <= hdr_next;
                        timer <= 32'(TIMEOUT_CYCLES);
                    end else if (timer_done) begin
                        state <= ST_ABORT;
                    end
                end
                ST_HDR_ANS: begin
                    if (!reply_pend) begin
                        reply_pend <= 1'b1;
                        hdr_cnt <= 5'h0;
                        lrc <= 8'h0;
                        hdr_bad <= 1'b0;
                        timer <= 32'(TIMEOUT_CYCLES);
                        byte_cnt <= 9'h0;
                        blk_idx <= 8'h0;
                        got_first <= 1'b0;
                        if (!hdr_bad) begin
                            reply <= CH_ACK;
                            hdr_ok_o <= 1'b1;
                            retries <= 2'h0;
                            state <= write_dir_o ? ST_RX_BLK : ST_TX_BLK;
                        end else if (retries == 2'(RETRY_MAX)) begin
                            reply <= CH_EOT;
                            state <= ST_DONE;
                            abort_o <= 1'b1;
                        end else begin
                            reply <= CH_NAK;
                            retries <= retries + 2'h1;
                            state <= ST_HDR;
                        end
                    end
                end
                ST_RX_BLK: begin
                    if (rx_valid_i) begin
                        rx_byte_o <= rx_data_i;
                        rx_byte_valid_o <= 1'b1;
                        if (!got_first) begin
                            got_first <= 1'b1;
                            timer <= 32'(TIMEOUT_CYCLES);
                        end
                        byte_cnt <= byte_cnt + 9'h1;
                        if (byte_cnt + 9'h1 == blk_len) begin
                            state <= ST_RX_ANS;
                            blk_end_o <= 1'b1;
                        end
                    end else if (timer_done) begin
                        state <= ST_ABORT;
                    end
                end
                ST_RX_ANS: begin
                    // Checker answers blk_ok_i one cycle after blk_end_o
                    if (!reply_pend && !blk_end_o) begin
                        reply_pend <= 1'b1;
                        byte_cnt <= 9'h0;
                        got_first <= 1'b0;
                        timer <= 32'(TIMEOUT_CYCLES);
                        if (blk_ok_i) begin
                            reply <= CH_ACK;
                            retries <= 2'h0;
                            blk_idx <= blk_idx + 8'h1;
                            state <= last_blk ? ST_RD_EOT : ST_RX_BLK;
                        end else if (retries == 2'(RETRY_MAX)) begin
                            reply <= CH_EOT;
                            state <= ST_DONE;
                            abort_o <= 1'b1;
                        end else begin
                            reply <= CH_NAK;
                            retries <= retries + 2'h1;
                            state <= ST_RX_BLK;
                        end
                    end
                end
                ST_TX_BLK: begin
                    if (src_push) begin
                        byte_cnt <= byte_cnt + 9'h1;
                        if (byte_cnt + 9'h1 == blk_len) begin
                            state <= ST_TX_WAIT;
                            blk_end_o <= 1'b1;
                            timer <= 32'(TIMEOUT_CYCLES);
                        end
                    end
                end
                ST_TX_WAIT: begin
                    if (rx_valid_i) begin
                        byte_cnt <= 9'h0;
                        timer <= 32'(TIMEOUT_CYCLES);
                        if (rx_data_i == CH_ACK) begin
                            retries <= 2'h0;
                            blk_idx <= blk_idx + 8'h1;
                            if (last_blk) begin
                                reply <= CH_EOT;
                                reply_pend <= 1'b1;
                                state <= ST_RD_EOT;
                            end else begin
                                state <= ST_TX_BLK;
                            end
                        end else if (rx_data_i == CH_NAK && retries != 2'(RETRY_MAX)) begin
                            retries <= retries + 2'h1;
                            state <= ST_TX_BLK;
                        end else begin
                            state <= ST_ABORT;
                        end
                    end else if (timer_done) begin
                        state <= ST_ABORT;
                    end
                end
                ST_RD_EOT: begin
                    if (rx_valid_i && rx_data_i == CH_EOT) begin
                        state <= ST_HUNT;
                        done_o <= 1'b1;
                    end else if (rx_valid_i || timer_done) begin
                        state <= ST_ABORT;
                    end
                end
                ST_ABORT: begin
                    if (!reply_pend) begin
                        reply <= CH_EOT;
                        reply_pend <= 1'b1;
                        abort_o <= 1'b1;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Wait for the closing EOT to leave before hunting again
                    if (!reply_pend && buf_cnt == 2'h0) begin
                        state <= ST_HUNT;
                    end
                end
                default: state <= ST_HUNT;
            endcase
        end
    end

    // Buffer holds bytes so a stalled UART loses nothing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_cnt <= 2'h0;
            buf_wr_ptr <= 1'b0;
            buf_rd_ptr <= 1'b0;
            buf_data[0] <= 8'h0;
            buf_data[1] <= 8'h0;
        end else begin
            if (buf_push || src_push) begin
                buf_data[buf_wr_ptr] <= buf_push ? reply : blk_data_i;
                buf_wr_ptr <= !buf_wr_ptr;
            end
            if (buf_pop) begin
                buf_rd_ptr <= !buf_rd_ptr;
            end
            buf_cnt <= buf_cnt + 2'((buf_push || src_push) ? 1 : 0) - 2'(buf_pop ? 1 : 0);
        end
    end
endmodule

// ### logic/msbtl_pkg.sv
package msbtl_pkg;
    localparam logic [7:0] CH_SOH = 8'h01;
    localparam logic [7:0] CH_EOT = 8'h04;
    localparam logic [7:0] CH_ENQ = 8'h05;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;
    localparam logic [7:0] CH_ETB = 8'h17;
    localparam logic [7:0] CH_NORMAL = 8'h4E;
    localparam logic [7:0] ADDR_OFFSET = 8'h20;
    localparam logic [7:0] DIR_READ = 8'h30;
    localparam int HDR_LEN = 17;
    localparam int HDR_FIELD_LAST = 15;
    localparam int HDR_DIR_POS = 4;
    localparam int BLOCK_MAX = 256;
    localparam int RETRY_MAX = 3;
    localparam int CLK_HZ = 50000000;
    localparam int QUIET_MS = 10;
    localparam int QUIET_CYC = QUIET_MS * (CLK_HZ / 1000);
    localparam int QUIET_CHARS = 4;
    localparam int TMO_MS = 1000;
    localparam int TMO_CYC = TMO_MS * (CLK_HZ / 1000);
    localparam int BYTE_TIME_CYC = 5209;
    typedef enum logic [3:0] {
        ST_HUNT, ST_QUIET, ST_REPLY, ST_HDR, ST_HDR_ANS, ST_RX_BLK, ST_RX_ANS,
        ST_TX_BLK, ST_TX_WAIT, ST_RD_EOT, ST_ABORT, ST_DONE
    } msbtl_state_t;
endpackage

// ### verification/msbtl_host_model.sv
`timescale 1ns/100ps
module msbtl_host_model (
    input wire logic clk_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic tx_ready_o
);
    logic slow = 1'b0;
    logic [7:0] got[$];
    int ph = 0;
    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b1;
    end
    // Slow host takes a byte only every third cycle
    always @(posedge clk_i) begin
        ph <= ph + 1;
        tx_ready_o <= !slow || (ph % 3 == 0);
        if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    end
    // Gap kept short, idle slaves would otherwise see a pause
    task automatic put(input logic [7:0] b);
        @(posedge clk_i);
        rx_data_o <= b;
        rx_valid_o <= 1'b1;
        @(posedge clk_i);
        rx_data_o <= ~b;
        rx_valid_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// ### verification/msbtl_link_asserts.sv
`timescale 1ns/100ps
module msbtl_link_asserts
    import msbtl_pkg::*;
#(
    parameter int QUIET_CYCLES = 50,
    parameter int CHAR_CYCLES = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic blk_data_ready_o,
    input wire logic hdr_ok_o,
    input wire logic write_dir_o,
    input wire logic done_o,
    input wire logic abort_o
);
    logic [31:0] quiet;
    logic [7:0] last_rx;
    logic [1:0] rx_seen;
    logic [3:0] since_eot;
    wire eot_out = tx_valid_o && tx_data_o == CH_EOT;
    // Saturating so a long idle never wraps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quiet <= '0;
            last_rx <= 8'h00;
            rx_seen <= 2'h0;
            since_eot <= 4'hF;
        end else begin
            quiet <= rx_valid_i ? '0 : quiet + 32'(quiet != 32'hFFFFFFFF);
            last_rx <= rx_valid_i ? rx_data_i : last_rx;
            rx_seen <= rx_seen + 2'(rx_valid_i && rx_seen != 2'h3);
            since_eot <= eot_out ? 4'h0 : since_eot + 4'(since_eot != 4'hF);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_tx_hold_byte: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o))
        else $error("tx byte changed before taken");
    chk_quiet_wait: assert property ($rose(tx_valid_o) && last_rx == CH_ENQ |->
        quiet >= QUIET_CYCLES + QUIET_CHARS * CHAR_CYCLES)
        else $error("enquiry reply before quiet time");
    chk_no_initiate: assert property ($rose(tx_valid_o) |-> rx_seen == 2'h3)
        else $error("tx before any enquiry");
    chk_hdr_ack: assert property (hdr_ok_o |-> ##[0:8] (tx_valid_o && tx_data_o == CH_ACK))
        else $error("accepted header without ACK");
    chk_abort_eot: assert property (abort_o |-> ##[0:16] (since_eot < 4'h9))
        else $error("abort without EOT");
    chk_read_only_fetch: assert property (blk_data_ready_o |-> !write_dir_o)
        else $error("block fetch in write direction");
    chk_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than a cycle");
    chk_done_excl: assert property (done_o |-> !abort_o ##1 !abort_o)
        else $error("done and abort together");
    cover property (done_o);
    cover property (abort_o);
    cover property (tx_valid_o && !tx_ready_i);
endmodule

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    import msbtl_pkg::*;
    localparam int QC = 50;
    localparam int CC = 5;
    localparam int LIM = 3000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] rx_data_i, tx_data_o, rx_byte_o, hdr_byte_o;
    logic [7:0] blk_data_i = 8'hA0;
    logic [7:0] blk_count_i = 8'h00;
    logic [8:0] last_len_i = 9'h003;
    logic blk_data_valid_i = 1'b1;
    logic [7:0] hdr_dir_seen = 8'h00;
    logic [7:0] last_rx_byte = 8'h00;
    int n_blk_end = 0;
    logic rx_valid_i, tx_valid_o, tx_ready_i, blk_data_ready_o, rx_byte_valid_o, hdr_byte_valid_o;
    logic hdr_ok_o, write_dir_o, blk_end_o, busy_o, done_o, abort_o;
    logic blk_ok_i = 1'b0;
    logic saw_done = 1'b0;
    logic saw_abort = 1'b0;
    logic [4:0] hdr_pos_o;
    int n_mismatch = 0;
    int n_checks = 0;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        // Source stalls every other cycle
        blk_data_valid_i <= !blk_data_valid_i;
        if (blk_data_ready_o && blk_data_valid_i) blk_data_i <= blk_data_i + 8'h01;
        // Rewind so that a resent block repeats its bytes
        if (blk_end_o) blk_data_i <= 8'hA0;
        if (blk_end_o) n_blk_end <= n_blk_end + 1;
        if (rx_byte_valid_o) last_rx_byte <= rx_byte_o;
        if (hdr_byte_valid_o && hdr_pos_o == 5'h04) hdr_dir_seen <= hdr_byte_o;
        if (done_o) saw_done <= 1'b1;
        if (abort_o) saw_abort <= 1'b1;
    end
    msbtl_link #(.QUIET_CYCLES(QC), .CHAR_CYCLES(CC), .TIMEOUT_CYCLES(200), .BLK_BYTES(4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .unit_id_i(7'h05), .rx_data_i(rx_data_i),
        .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .blk_count_i(blk_count_i), .last_len_i(last_len_i),
        .blk_data_i(blk_data_i), .blk_data_valid_i(blk_data_valid_i),
        .blk_data_ready_o(blk_data_ready_o),
        .blk_ok_i(blk_ok_i), .rx_byte_o(rx_byte_o), .rx_byte_valid_o(rx_byte_valid_o),
        .hdr_byte_o(hdr_byte_o), .hdr_pos_o(hdr_pos_o), .hdr_byte_valid_o(hdr_byte_valid_o),
        .hdr_ok_o(hdr_ok_o), .write_dir_o(write_dir_o), .blk_end_o(blk_end_o),
        .busy_o(busy_o), .done_o(done_o), .abort_o(abort_o));
    msbtl_host_model host_u (.clk_i(clk_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
        .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Zero waits for the session to go idle
    task automatic wait_tx(input int n);
        int k;
        k = 0;
        while ((n > 0 ? host_u.got.size() < n : busy_o !== 1'b0) && k < LIM) begin
            @(posedge clk_i);
            k++;
        end
        if (k == LIM) begin
            chk("wait bound", 8'h01, 8'h00);
            tally_and_finish();
        end
    endtask
    task automatic enq(input logic [7:0] addr);
        host_u.got.delete();
        saw_done <= 1'b0;
        saw_abort <= 1'b0;
        n_blk_end <= 0;
        host_u.put(CH_NORMAL);
        host_u.put(addr);
        host_u.put(CH_ENQ);
    endtask
    task automatic send_hdr(input logic [7:0] soh, dir, mt, flip);
        logic [7:0] h[17];
        logic [7:0] lrc;
        h = '{soh, 8'h30, 8'h35, dir, mt, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30,
            8'h30, 8'h33, 8'h30, 8'h31, CH_ETB, 8'h00};
        lrc = 8'h00;
        for (int i = 1; i < 15; i++) lrc ^= h[i];
        h[16] = lrc ^ flip;
        foreach (h[i]) host_u.put(h[i]);
    endtask
    task automatic s_hunt();
        enq(8'h26);
        repeat (QC + 4 * CC + 20) @(posedge clk_i);
        chk("foreign enquiry tx", 8'(host_u.got.size()), 8'h00);
        enq(8'h25);
        repeat (10) @(posedge clk_i);
        host_u.put(8'h33);
        repeat (QC + 4 * CC + 20) @(posedge clk_i);
        chk("cancelled enquiry tx", 8'(host_u.got.size()), 8'h00);
        repeat (QC) @(posedge clk_i); // Host pause before retrying
    endtask
    task automatic s_hdr_timeout();
        enq(8'h25); // Retry of the cancelled enquiry
        wait_tx(2);
        chk("enquiry reply", host_u.got[0], CH_ACK);
        chk("header timeout", host_u.got[1], CH_EOT);
        chk("timeout abort", {7'h00, saw_abort}, 8'h01);
        wait_tx(0);
    endtask
    // Three refusals are allowed, the fourth bad header ends the session
    task automatic s_hdrs(input logic last_good);
        logic [7:0] want;
        enq(8'h25);
        wait_tx(1); // Header only after the enquiry reply
        for (int i = 0; i < 4; i++) begin
            if (last_good) begin
                send_hdr(i == 0 ? 8'h02 : CH_SOH, 8'h38, i == 1 ? 8'h47 : 8'h31,
                    i == 2 ? 8'hFF : 8'h00);
            end else begin
                send_hdr(CH_SOH, 8'h38, 8'h31, 8'hFF);
            end
            wait_tx(i + 2);
            want = i < 3 ? CH_NAK : last_good ? CH_ACK : CH_EOT;
            chk("header reply", host_u.got[i + 1], want);
        end
    endtask
    task automatic blk(input logic ok, input int n);
        blk_ok_i <= ok;
        for (int i = 1; i <= n; i++) host_u.put(8'(i * 17));
    endtask
    // One full block of four, then a last block of two
    task automatic s_write();
        blk_count_i <= 8'h01;
        last_len_i <= 9'h002;
        s_hdrs(1'b1);
        chk("write dir", {7'h00, write_dir_o}, 8'h01);
        chk("write header dir byte", hdr_dir_seen, 8'h38);
        blk(1'b0, 4);
        wait_tx(6);
        chk("bad block reply", host_u.got[5], CH_NAK);
        blk(1'b1, 4);
        wait_tx(7);
        chk("full block reply", host_u.got[6], CH_ACK);
        blk(1'b1, 2);
        wait_tx(8);
        chk("last block reply", host_u.got[7], CH_ACK);
        chk("last block byte", last_rx_byte, 8'h22);
        chk("write block ends", 8'(n_blk_end), 8'h03);
        host_u.put(CH_EOT);
        wait_tx(0);
        chk("write done", {7'h00, saw_done}, 8'h01);
        blk_count_i <= 8'h00;
        last_len_i <= 9'h003;
    endtask
    task automatic s_read();
        host_u.slow <= 1'b1;
        enq(8'h25);
        wait_tx(1);
        send_hdr(CH_SOH, 8'h30, 8'h31, 8'h00);
        wait_tx(5);
        chk("read header reply", host_u.got[1], CH_ACK);
        chk("read dir", {7'h00, write_dir_o}, 8'h00);
        chk("read header dir byte", hdr_dir_seen, 8'h30);
        for (int i = 0; i < 3; i++) chk("block byte", host_u.got[i + 2], 8'hA0 + 8'(i));
        host_u.put(CH_NAK);
        wait_tx(8);
        for (int i = 0; i < 3; i++) chk("resent byte", host_u.got[i + 5], 8'hA0 + 8'(i));
        host_u.put(CH_ACK);
        wait_tx(9);
        chk("closing eot", host_u.got[8], CH_EOT);
        chk("read block ends", 8'(n_blk_end), 8'h02);
        host_u.put(CH_EOT);
        wait_tx(0);
        chk("read done", {7'h00, saw_done}, 8'h01);
        host_u.slow <= 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        s_hunt();
        s_hdr_timeout();
        s_hdrs(1'b0);
        wait_tx(0);
        chk("retry abort", {7'h00, saw_abort}, 8'h01);
        s_write();
        s_read();
        tally_and_finish();
    end
endmodule
bind msbtl_link msbtl_link_asserts #(.QUIET_CYCLES(QUIET_CYCLES), .CHAR_CYCLES(CHAR_CYCLES))
    chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .blk_data_ready_o(blk_data_ready_o), .hdr_ok_o(hdr_ok_o), .write_dir_o(write_dir_o),
    .done_o(done_o), .abort_o(abort_o));
